// >>> rtl/pmx_top.v
// processor-mode pin multiplexer with APB register access
`timescale 1ns/1ns
`include "pmx_regs.vh"
module pmx_top #(
   parameter PORT_W = 8
)(
   // clock and reset
   input wire MCLK,
   input wire RST,
   // device pins: strap, reset, width select, enable
   input wire MODE_STRAP_PIN,
   input wire RESET_PIN_N,
   input wire BUS_WIDTH_SEL,
   output reg E_PIN,
   output reg DEVICE_RESET,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // bus interface unit side, pin levels
   input wire [23:0] BIU_ADDR,
   input wire BIU_RD_STROBE,
   input wire BIU_WR_STROBE,
   input wire BIU_HIGH_BYTE_ENABLE,
   input wire BIU_ALE,
   input wire BIU_HOLD_ACKNOWLEDGE,
   input wire BIU_PHI1,
   input wire BIU_ENABLE,
   input wire BIU_WRITE_CYCLE,
   input wire [4:0] BIU_CHIP_SELECT_OUTPUT,
   input wire [7:0] BIU_WDATA,
   output reg [7:0] BIU_RDATA,
   output reg BIU_HOLD_REQ,
   output reg BIU_READY,
   output reg BIU_BUS_8BIT,
   output reg [1:0] PROC_MODE,
   // peripheral function side, ports 5 to 9
   input wire [7:0] P5_FN_OUT,
   input wire [7:0] P5_FN_OE,
   output reg [7:0] P5_FN_IN,
   input wire [7:0] P6_FN_OUT,
   input wire [7:0] P6_FN_OE,
   output reg [7:0] P6_FN_IN,
   input wire [7:0] P7_FN_OUT,
   input wire [7:0] P7_FN_OE,
   output reg [7:0] P7_FN_IN,
   input wire [7:0] P8_FN_OUT,
   input wire [7:0] P8_FN_OE,
   output reg [7:0] P8_FN_IN,
   input wire [5:0] P9_FN_OUT,
   input wire [5:0] P9_FN_OE,
   output reg [5:0] P9_FN_IN,
   // port pins 0 to 10
   input wire [7:0] P0_IN,
   output reg [7:0] P0_OUT,
   output reg [7:0] P0_OE,
   input wire [7:0] P1_IN,
   output reg [7:0] P1_OUT,
   output reg [7:0] P1_OE,
   input wire [4:0] P2_IN,
   output reg [4:0] P2_OUT,
   output reg [4:0] P2_OE,
   input wire [3:0] P3_IN,
   output reg [3:0] P3_OUT,
   output reg [3:0] P3_OE,
   input wire [7:0] P4_IN,
   output reg [7:0] P4_OUT,
   output reg [7:0] P4_OE,
   input wire [7:0] P5_IN,
   output reg [7:0] P5_OUT,
   output reg [7:0] P5_OE,
   input wire [7:0] P6_IN,
   output reg [7:0] P6_OUT,
   output reg [7:0] P6_OE,
   input wire [7:0] P7_IN,
   output reg [7:0] P7_OUT,
   output reg [7:0] P7_OE,
   input wire [7:0] P8_IN,
   output reg [7:0] P8_OUT,
   output reg [7:0] P8_OE,
   input wire [5:0] P9_IN,
   output reg [5:0] P9_OUT,
   output reg [5:0] P9_OE,
   input wire [7:0] P10_IN,
   output reg [7:0] P10_OUT,
   output reg [7:0] P10_OE
);

   // port index from a word address within a bank, valid below the port count
   function port_ok;
      input [11:0] addr;
      input [11:0] base;
      begin
         port_ok = ((addr & `PMX_BANK_MASK) == base) && (addr[5:2] < `PMX_NPORT);
      end
   endfunction

   integer i;
   // separate loop index for the clocked process, so no variable has two drivers
   integer k;
   reg [31:0] ctrl_reg;
   reg [31:0] buscfg_reg;
   reg [PORT_W-1:0] dir_reg [0:`PMX_NPORT-1];
   reg [PORT_W-1:0] data_reg [0:`PMX_NPORT-1];
   reg [PORT_W-1:0] fsel_reg [0:`PMX_NPORT-1];
   reg [PORT_W-1:0] o_next [0:`PMX_NPORT-1];
   reg [PORT_W-1:0] e_next [0:`PMX_NPORT-1];
   reg [31:0] rdata_next;
   reg slverr_next;
   reg [1:0] mode_next;
   wire [PORT_W-1:0] pin_in [0:`PMX_NPORT-1];
   wire [PORT_W-1:0] fn_out [0:`PMX_NPORT-1];
   wire [PORT_W-1:0] fn_oe [0:`PMX_NPORT-1];
   wire dev_rst = ~RESET_PIN_N;
   wire ext_mode = (mode_next != `PMX_MODE_SC);
   wire [3:0] idx = PADDR[5:2];
   wire apb_setup = PSEL & ~PENABLE;
   wire apb_write = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

   // narrow ports padded to the common width, port 2 bit 4 is pin 7
   assign pin_in[0] = P0_IN;
   assign pin_in[1] = P1_IN;
   assign pin_in[2] = {3'h0, P2_IN};
   assign pin_in[3] = {4'h0, P3_IN};
   assign pin_in[4] = P4_IN;
   assign pin_in[5] = P5_IN;
   assign pin_in[6] = P6_IN;
   assign pin_in[7] = P7_IN;
   assign pin_in[8] = P8_IN;
   assign pin_in[9] = {2'h0, P9_IN};
   assign pin_in[10] = P10_IN;
   assign fn_out[5] = P5_FN_OUT;
   assign fn_out[6] = P6_FN_OUT;
   assign fn_out[7] = P7_FN_OUT;
   assign fn_out[8] = P8_FN_OUT;
   assign fn_out[9] = {2'h0, P9_FN_OUT};
   assign fn_oe[5] = P5_FN_OE;
   assign fn_oe[6] = P6_FN_OE;
   assign fn_oe[7] = P7_FN_OE;
   assign fn_oe[8] = P8_FN_OE;
   assign fn_oe[9] = {2'h0, P9_FN_OE};
   genvar g;
   generate
      for (g = 0; g < `PMX_FIRST_FN; g = g + 1)
      begin : g_nofn
         assign fn_out[g] = 8'h00;
         assign fn_oe[g] = 8'h00;
      end
      assign fn_out[10] = 8'h00;
      assign fn_oe[10] = 8'h00;
   endgenerate

   // processor mode from the strap and the expansion control bit
   always @*
   begin
      if (MODE_STRAP_PIN)
         mode_next = `PMX_MODE_MP;
      else if (ctrl_reg[`PMX_CTRL_MEMEXP])
         mode_next = `PMX_MODE_MX;
      else
         mode_next = `PMX_MODE_SC;
   end

   // pin level and enable per port
   always @*
   begin
      for (i = 0; i < `PMX_NPORT; i = i + 1)
      begin
         // peripheral function owns selected pins, otherwise direction/data registers
         o_next[i] = (fsel_reg[i] & fn_out[i]) | (~fsel_reg[i] & data_reg[i]);
         e_next[i] = (fsel_reg[i] & fn_oe[i]) | (~fsel_reg[i] & dir_reg[i]);
      end
      // ports 5 to 8 keep their peripheral muxing in every mode, port 9 unless buscfg_reg gives its pins to the bus
      if (ext_mode)
      begin
         o_next[0] = BIU_ADDR[7:0];
         e_next[0] = 8'hFF;
         o_next[1] = BIU_ADDR[15:8];
         e_next[1] = 8'hFF;
         o_next[2] = {3'h0, BIU_ADDR[23], BIU_ADDR[19:16]};
         e_next[2] = 8'h1F;
         o_next[3] = {4'h0, BIU_HOLD_ACKNOWLEDGE, BIU_ALE, BIU_HIGH_BYTE_ENABLE, BIU_WR_STROBE};
         e_next[3] = 8'h0F;
         // hold request and ready are inputs here
         o_next[4][1:0] = 2'h0;
         e_next[4][1:0] = 2'h0;
         if (!(mode_next == `PMX_MODE_MX && ctrl_reg[`PMX_CTRL_CLKIO]))
         begin
            o_next[4][2] = BIU_PHI1;
            e_next[4][2] = 1'b1;
         end
         // port 9 bus functions: address 20-22 on pins 0-2, chip selects on pins 1-5
         for (i = 1; i < 6; i = i + 1)
         begin
            if (buscfg_reg[`PMX_BUSCFG_CS_LO + i - 1])
            begin
               o_next[9][i] = BIU_CHIP_SELECT_OUTPUT[i - 1];
               e_next[9][i] = 1'b1;
            end
         end
         if (buscfg_reg[`PMX_BUSCFG_ADDR])
         begin
            o_next[9][2:0] = BIU_ADDR[22:20];
            e_next[9][2:0] = 3'h7;
         end
         // data pins drive on every write, float on reads
         o_next[10] = BIU_WDATA;
         e_next[10] = {8{BIU_WRITE_CYCLE}};
      end
   end

   // register read mux and unmapped decode
   always @*
   begin
      rdata_next = 32'h0000_0000;
      slverr_next = 1'b0;
      if (PADDR == `PMX_CTRL_OFS)
         rdata_next = ctrl_reg;
      else if (PADDR == `PMX_STAT_OFS)
      begin
         rdata_next[`PMX_STAT_STRAP] = MODE_STRAP_PIN;
         rdata_next[`PMX_STAT_MODE_LO + 1 -: 2] = mode_next;
         rdata_next[`PMX_STAT_BYTE] = BUS_WIDTH_SEL;
         rdata_next[`PMX_STAT_INRST] = dev_rst;
      end
      else if (PADDR == `PMX_BUSCFG_OFS)
         rdata_next = buscfg_reg;
      else if (port_ok(PADDR, `PMX_DIR_BASE))
         rdata_next[PORT_W-1:0] = dir_reg[idx];
      else if (port_ok(PADDR, `PMX_DATA_BASE))
         rdata_next[PORT_W-1:0] = data_reg[idx];
      else if (port_ok(PADDR, `PMX_PIN_BASE))
         rdata_next[PORT_W-1:0] = pin_in[idx];
      else if (port_ok(PADDR, `PMX_FSEL_BASE) && idx >= `PMX_FIRST_FN && idx <= `PMX_LAST_FN)
         rdata_next[PORT_W-1:0] = fsel_reg[idx];
      else
         slverr_next = 1'b1;
   end

   // apb handshake: one wait-free access phase, answer registered in setup
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end
      else
      begin
         PREADY <= apb_setup;
         PSLVERR <= apb_setup & slverr_next;
         if (apb_setup)
            PRDATA <= rdata_next;
      end
   end

   // configuration registers, cleared while the reset pin is low
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         ctrl_reg <= `PMX_CTRL_RST;
         buscfg_reg <= `PMX_BUSCFG_RST;
         for (k = 0; k < `PMX_NPORT; k = k + 1)
         begin
            dir_reg[k] <= `PMX_DIR_RST;
            data_reg[k] <= `PMX_DATA_RST;
            fsel_reg[k] <= `PMX_FSEL_RST;
         end
      end
      else if (dev_rst)
      begin
         ctrl_reg <= `PMX_CTRL_RST;
         buscfg_reg <= `PMX_BUSCFG_RST;
         for (k = 0; k < `PMX_NPORT; k = k + 1)
         begin
            dir_reg[k] <= `PMX_DIR_RST;
            data_reg[k] <= `PMX_DATA_RST;
            fsel_reg[k] <= `PMX_FSEL_RST;
         end
      end
      else if (apb_write)
      begin
         if (PADDR == `PMX_CTRL_OFS)
            ctrl_reg <= {30'h0000_0000, PWDATA[1:0]};
         else if (PADDR == `PMX_BUSCFG_OFS)
            buscfg_reg <= {26'h000_0000, PWDATA[5:0]};
         else if (port_ok(PADDR, `PMX_DIR_BASE))
            dir_reg[idx] <= PWDATA[PORT_W-1:0];
         else if (port_ok(PADDR, `PMX_DATA_BASE))
            data_reg[idx] <= PWDATA[PORT_W-1:0];
         else if (port_ok(PADDR, `PMX_FSEL_BASE))
            fsel_reg[idx] <= PWDATA[PORT_W-1:0];
      end
   end

   // registered pins and bus-side outputs
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         E_PIN <= 1'b1;
         DEVICE_RESET <= 1'b1;
         BIU_RDATA <= 8'h00;
         BIU_HOLD_REQ <= 1'b1;
         BIU_READY <= 1'b1;
         BIU_BUS_8BIT <= 1'b0;
         PROC_MODE <= `PMX_MODE_SC;
         P5_FN_IN <= 8'h00;
         P6_FN_IN <= 8'h00;
         P7_FN_IN <= 8'h00;
         P8_FN_IN <= 8'h00;
         P9_FN_IN <= 6'h00;
         P0_OUT <= 8'h00;
         P0_OE <= 8'h00;
         P1_OUT <= 8'h00;
         P1_OE <= 8'h00;
         P2_OUT <= 5'h00;
         P2_OE <= 5'h00;
         P3_OUT <= 4'h0;
         P3_OE <= 4'h0;
         P4_OUT <= 8'h00;
         P4_OE <= 8'h00;
         P5_OUT <= 8'h00;
         P5_OE <= 8'h00;
         P6_OUT <= 8'h00;
         P6_OE <= 8'h00;
         P7_OUT <= 8'h00;
         P7_OE <= 8'h00;
         P8_OUT <= 8'h00;
         P8_OE <= 8'h00;
         P9_OUT <= 6'h00;
         P9_OE <= 6'h00;
         P10_OUT <= 8'h00;
         P10_OE <= 8'h00;
      end
      else
      begin
         DEVICE_RESET <= dev_rst;
         E_PIN <= ext_mode ? BIU_RD_STROBE : BIU_ENABLE;
         BIU_RDATA <= P10_IN;
         BIU_HOLD_REQ <= ext_mode ? P4_IN[0] : 1'b1;
         BIU_READY <= ext_mode ? P4_IN[1] : 1'b1;
         BIU_BUS_8BIT <= ext_mode & BUS_WIDTH_SEL;
         PROC_MODE <= mode_next;
         P5_FN_IN <= P5_IN;
         P6_FN_IN <= P6_IN;
         P7_FN_IN <= P7_IN;
         P8_FN_IN <= P8_IN;
         P9_FN_IN <= P9_IN;
         P0_OUT <= o_next[0];
         P0_OE <= e_next[0];
         P1_OUT <= o_next[1];
         P1_OE <= e_next[1];
         P2_OUT <= o_next[2][4:0];
         P2_OE <= e_next[2][4:0];
         P3_OUT <= o_next[3][3:0];
         P3_OE <= e_next[3][3:0];
         P4_OUT <= o_next[4];
         P4_OE <= e_next[4];
         P5_OUT <= o_next[5];
         P5_OE <= e_next[5];
         P6_OUT <= o_next[6];
         P6_OE <= e_next[6];
         P7_OUT <= o_next[7];
         P7_OE <= e_next[7];
         P8_OUT <= o_next[8];
         P8_OE <= e_next[8];
         P9_OUT <= o_next[9][5:0];
         P9_OE <= e_next[9][5:0];
         P10_OUT <= o_next[10];
         P10_OE <= e_next[10];
      end
   end

endmodule // pmx_top

// >>> include/pmx_regs.vh
// register offsets, field positions, reset values and mode codes of the pin multiplexer
`ifndef PMX_REGS_VH
`define PMX_REGS_VH

// register byte offsets
`define PMX_CTRL_OFS 12'h000
`define PMX_STAT_OFS 12'h004
`define PMX_BUSCFG_OFS 12'h008
`define PMX_DIR_BASE 12'h040
`define PMX_DATA_BASE 12'h080
`define PMX_PIN_BASE 12'h0C0
`define PMX_FSEL_BASE 12'h100
`define PMX_BANK_MASK 12'hFC0

// control register fields
`define PMX_CTRL_MEMEXP 0
`define PMX_CTRL_CLKIO 1
`define PMX_CTRL_RST 32'h0000_0000

// bus configuration register fields
`define PMX_BUSCFG_ADDR 0
`define PMX_BUSCFG_CS_LO 1
`define PMX_BUSCFG_RST 32'h0000_0000

// status register fields
`define PMX_STAT_STRAP 0
`define PMX_STAT_MODE_LO 1
`define PMX_STAT_BYTE 3
`define PMX_STAT_INRST 4

// port register reset values: all pins inputs, data low
`define PMX_DIR_RST 8'h00
`define PMX_DATA_RST 8'h00
`define PMX_FSEL_RST 8'h00

// processor modes
`define PMX_MODE_SC 2'h0
`define PMX_MODE_MX 2'h1
`define PMX_MODE_MP 2'h2

// port numbering
`define PMX_NPORT 11
`define PMX_FIRST_FN 5
`define PMX_LAST_FN 9

`endif

// >>> dv/pmx_checker.sv
// concurrent checks on the pin multiplexer ports
`timescale 1ns/1ns
module pmx_checker (
   // clock and reset
   input wire MCLK,
   input wire RST,
   // mode, reset and width pins
   input wire MODE_STRAP_PIN,
   input wire RESET_PIN_N,
   input wire BUS_WIDTH_SEL,
   input wire E_PIN,
   input wire DEVICE_RESET,
   // apb handshake
   input wire PSEL,
   input wire PENABLE,
   input wire PREADY,
   // bus unit side
   input wire [23:0] BIU_ADDR,
   input wire BIU_RD_STROBE,
   input wire BIU_WR_STROBE,
   input wire BIU_HIGH_BYTE_ENABLE,
   input wire BIU_ALE,
   input wire BIU_HOLD_ACKNOWLEDGE,
   input wire BIU_ENABLE,
   input wire BIU_HOLD_REQ,
   input wire BIU_READY,
   input wire BIU_BUS_8BIT,
   input wire [1:0] PROC_MODE,
   // port pins
   input wire [7:0] P4_IN,
   input wire [7:0] P0_OUT,
   input wire [7:0] P0_OE,
   input wire [7:0] P1_OUT,
   input wire [7:0] P1_OE,
   input wire [4:0] P2_OUT,
   input wire [4:0] P2_OE,
   input wire [3:0] P3_OUT
);
   reg [23:0] addr_reg;
   reg [3:0] ctl_reg;
   reg [1:0] hr_reg;
   // one-cycle copies of the bus unit levels the pins must follow, and of the port 4 hold and ready pins
   always @(posedge MCLK)
   begin
      addr_reg <= BIU_ADDR;
      ctl_reg <= {BIU_HOLD_ACKNOWLEDGE, BIU_ALE, BIU_HIGH_BYTE_ENABLE, BIU_WR_STROBE};
      hr_reg <= P4_IN[1:0];
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // attempts start only once reset is sampled low, so no $past reaches into reset
   property p_mode; MODE_STRAP_PIN |=> PROC_MODE == 2'h2; endproperty
   a_mode: assert property (p_mode) else $error("strap high without processor mode");
   property p_rpin; !RESET_PIN_N |=> DEVICE_RESET; endproperty
   a_rpin: assert property (p_rpin) else $error("reset pin low not held");
   property p_esc; !RST |=> PROC_MODE != 2'h0 || E_PIN == $past(BIU_ENABLE); endproperty
   a_esc: assert property (p_esc) else $error("enable pin wrong in single-chip");
   property p_erd; !RST |=> PROC_MODE == 2'h0 || E_PIN == $past(BIU_RD_STROBE); endproperty
   a_erd: assert property (p_erd) else $error("read strobe wrong");
   property p_width; !RST |=> BIU_BUS_8BIT == (PROC_MODE != 2'h0 && $past(BUS_WIDTH_SEL)); endproperty
   a_width: assert property (p_width) else $error("bus width wrong");
   property p_dir; !RESET_PIN_N [*2] |=> PROC_MODE != 2'h0 || P0_OE == 8'h00; endproperty
   a_dir: assert property (p_dir) else $error("port 0 not input after reset");
   property p_addr;
      !RST |=> PROC_MODE == 2'h0 || {P2_OUT, P1_OUT, P0_OUT} == {addr_reg[23], addr_reg[19:0]};
   endproperty
   a_addr: assert property (p_addr) else $error("address pins wrong");
   property p_aoe; !RST |=> PROC_MODE == 2'h0 || (&P0_OE && &P1_OE && &P2_OE); endproperty
   a_aoe: assert property (p_aoe) else $error("address pins not driven");
   property p_ctl; !RST |=> PROC_MODE == 2'h0 || P3_OUT == ctl_reg; endproperty
   a_ctl: assert property (p_ctl) else $error("bus control pins wrong");
   property p_hold; !RST |=> {BIU_READY, BIU_HOLD_REQ} == ((PROC_MODE == 2'h0) ? 2'h3 : hr_reg); endproperty
   a_hold: assert property (p_hold) else $error("hold or ready input wrong");
   property p_rdy; PSEL && !PENABLE |=> PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("apb ready late");
endmodule // pmx_checker
bind pmx_top pmx_checker chk (.*);

// >>> dv/pmx_ext_mem.sv
// behavioural external memory and ready source on the expansion bus
`timescale 1ns/1ns
module pmx_ext_mem (
   // bus pins from the device
   input wire clk,
   input wire [7:0] addr_lo,
   input wire rd_n,
   input wire wr_n,
   input wire [7:0] dq_out,
   input wire [7:0] dq_oe,
   input wire slow,
   // lines back to the device
   output logic [7:0] dq_in,
   output logic rdy
);
   logic [7:0] mem [0:255];
   logic [7:0] last_reg = 8'h00;
   logic tgl_reg = 1'b0;
   always @(posedge clk)
   begin
      tgl_reg <= ~tgl_reg;
      if (!wr_n && &dq_oe)
         mem[addr_lo] <= dq_out;
      if (!rd_n)
         last_reg <= mem[addr_lo];
   end
   // a released data bus shows the inverse of its last value
   assign dq_in = !rd_n ? mem[addr_lo] : ~last_reg;
   assign rdy = slow ? tgl_reg : 1'b1;
endmodule // pmx_ext_mem

// >>> dv/pmx_top_tb.sv
// self-checking bench for the processor-mode pin multiplexer
`timescale 1ns/1ns
module pmx_top_tb;
   logic MCLK = 0, RST = 1, MODE_STRAP_PIN = 0, RESET_PIN_N = 1, BUS_WIDTH_SEL = 0, E_PIN, DEVICE_RESET;
   logic PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, hold_n = 1, slow = 0, rdy, err;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, rd;
   logic [23:0] BIU_ADDR = 0;
   logic BIU_RD_STROBE = 1, BIU_WR_STROBE = 1, BIU_HIGH_BYTE_ENABLE = 0, BIU_ALE = 0, BIU_HOLD_ACKNOWLEDGE = 0;
   logic BIU_PHI1 = 0, BIU_ENABLE = 0, BIU_WRITE_CYCLE = 0, BIU_HOLD_REQ, BIU_READY, BIU_BUS_8BIT;
   logic [4:0] BIU_CHIP_SELECT_OUTPUT = 0, P2_OUT, P2_OE;
   logic [7:0] BIU_WDATA = 0, BIU_RDATA, fo = 0, fe = 0, pin = 0, P10_IN, P0_OUT, P0_OE, P1_OUT, P1_OE;
   logic [7:0] P4_OUT, P4_OE, P5_OUT, P5_OE, P6_OUT, P6_OE, P7_OUT, P7_OE, P8_OUT, P8_OE, P10_OUT, P10_OE;
   logic [7:0] P5_FN_IN, P6_FN_IN, P7_FN_IN, P8_FN_IN;
   logic [1:0] PROC_MODE;
   logic [3:0] P3_OUT, P3_OE;
   logic [5:0] P9_OUT, P9_OE, P9_FN_IN;
   wire [7:0] P0_IN = pin, P1_IN = pin, P5_IN = pin, P6_IN = pin, P7_IN = pin, P8_IN = pin;
   wire [7:0] P4_IN = {pin[7:2], rdy, hold_n}, P5_FN_OUT = fo, P6_FN_OUT = fo, P7_FN_OUT = fo, P8_FN_OUT = fo;
   wire [7:0] P5_FN_OE = fe, P6_FN_OE = fe, P7_FN_OE = fe, P8_FN_OE = fe;
   wire [5:0] P9_FN_OUT = fo[5:0], P9_FN_OE = fe[5:0], P9_IN = pin[5:0];
   wire [4:0] P2_IN = pin[4:0];
   wire [3:0] P3_IN = pin[3:0];
   int n_mismatch = 0, total_checks = 0, cyc_n = 0;
   pmx_top uut (.*);
   pmx_ext_mem ext (.clk(MCLK), .addr_lo(P0_OUT), .rd_n(E_PIN), .wr_n(P3_OUT[0]), .dq_out(P10_OUT),
      .dq_oe(P10_OE), .slow(slow), .dq_in(P10_IN), .rdy(rdy));
   always #10 MCLK = ~MCLK;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge MCLK)
   begin
      cyc_n++;
      if (cyc_n == 3000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task md(input logic s, input logic [7:0] c);
      MODE_STRAP_PIN <= s;
      apb(1'b1, 12'h000, c);
      cyc(2);
   endtask
   task t_sc;
      chk("p0_oe_rst", 8'h00, P0_OE);
      apb(1'b1, 12'h040, 8'h5A);
      apb(1'b1, 12'h080, 8'hC3);
      apb(1'b1, 12'h044, 8'h0F);
      pin <= 8'h96;
      cyc(2);
      chk("p0_oe", 8'h5A, P0_OE);
      chk("p0_out", 8'h42, P0_OUT & 8'h5A);
      chk("p1_oe", 8'h0F, P1_OE);
      apb(1'b0, 12'h0C0, 0);
      chk("pin0", 8'h96, rd);
   endtask
   task t_mode;
      md(1'b0, 8'h01);
      chk("mode_mx", 2'h1, PROC_MODE);
      md(1'b1, 8'h00);
      chk("mode_mp", 2'h2, PROC_MODE);
      apb(1'b0, 12'h004, 0);
      chk("stat_mode", 2'h2, rd[2:1]);
      md(1'b0, 8'h00);
      chk("mode_sc", 2'h0, PROC_MODE);
   endtask
   task t_ext;
      BIU_ADDR <= 24'h9E_D25A;
      {BIU_HOLD_ACKNOWLEDGE, BIU_ALE, BIU_HIGH_BYTE_ENABLE, BIU_WR_STROBE} <= 4'h6;
      md(1'b1, 8'h00);
      chk("p0_out", 8'h5A, P0_OUT);
      chk("p0_oe", 8'hFF, P0_OE);
      chk("p1_out", 8'hD2, P1_OUT);
      chk("p2_out", 5'h1E, P2_OUT);
      chk("p3", 8'h6F, {P3_OUT, P3_OE});
   endtask
   task t_e;
      BIU_RD_STROBE <= 1'b0;
      BIU_ENABLE <= 1'b1;
      BUS_WIDTH_SEL <= 1'b1;
      cyc(2);
      chk("e_rd", 1'b0, E_PIN);
      chk("bus8", 1'b1, BIU_BUS_8BIT);
      md(1'b0, 8'h00);
      chk("e_sc", 1'b1, E_PIN);
      chk("bus8_sc", 1'b0, BIU_BUS_8BIT);
      BIU_RD_STROBE <= 1'b1;
      BUS_WIDTH_SEL <= 1'b0;
   endtask
   task t_p4;
      hold_n <= 1'b0;
      BIU_PHI1 <= 1'b1;
      md(1'b1, 8'h00);
      chk("hold", 1'b0, BIU_HOLD_REQ);
      chk("phi", 2'h3, {P4_OE[2], P4_OUT[2]});
      md(1'b0, 8'h01);
      chk("phi_mx", 2'h3, {P4_OE[2], P4_OUT[2]});
      // pin 2 as an output with data low, so the clock and the port differ
      apb(1'b1, 12'h050, 8'h04);
      md(1'b0, 8'h03);
      chk("p42_io", 2'h2, {P4_OE[2], P4_OUT[2]});
      hold_n <= 1'b1;
   endtask
   task t_fn;
      fo <= 8'hA5;
      fe <= 8'h3C;
      md(1'b0, 8'h00);
      for (int n = 5; n < 10; n++)
         apb(1'b1, 12'h100 + 12'(4 * n), 8'hFF);
      cyc(2);
      chk("p5", 16'h243C, {P5_OUT & fe, P5_OE});
      chk("p6", 16'h243C, {P6_OUT & fe, P6_OE});
      chk("p7", 16'h243C, {P7_OUT & fe, P7_OE});
      chk("p8", 16'h243C, {P8_OUT & fe, P8_OE});
      chk("p9", 16'h243C, {2'h0, P9_OUT & fe[5:0], 2'h0, P9_OE});
      chk("fn_in", 32'h9696_9696, {P5_FN_IN, P6_FN_IN, P7_FN_IN, P8_FN_IN});
      chk("p9_fn_in", 6'h16, P9_FN_IN);
   endtask
   task t_p9;
      BIU_CHIP_SELECT_OUTPUT <= 5'h15;
      md(1'b1, 8'h00);
      apb(1'b1, 12'h008, 8'h01);
      cyc(2);
      chk("p9_addr", 3'h1, P9_OUT[2:0]);
      apb(1'b1, 12'h008, 8'h3E);
      cyc(2);
      chk("p9_cs", 5'h15, P9_OUT[5:1]);
   endtask
   task t_mem;
      BIU_ADDR <= 24'h00_0033;
      BIU_WDATA <= 8'h77;
      BIU_WRITE_CYCLE <= 1'b1;
      cyc(3);
      chk("dq_oe_wr", 8'hFF, P10_OE);
      chk("bus16", 1'b0, BIU_BUS_8BIT);
      BIU_WRITE_CYCLE <= 1'b0;
      BIU_WR_STROBE <= 1'b1;
      BIU_RD_STROBE <= 1'b0;
      cyc(3);
      chk("dq_oe_rd", 8'h00, P10_OE);
      chk("rdata", 8'h77, BIU_RDATA);
      BIU_RD_STROBE <= 1'b1;
   endtask
   task t_rpin;
      MODE_STRAP_PIN <= 1'b0;
      RESET_PIN_N <= 1'b0;
      cyc(3);
      chk("dev_rst", 1'b1, DEVICE_RESET);
      chk("p0_oe_clr", 8'h00, P0_OE);
      RESET_PIN_N <= 1'b1;
      apb(1'b0, 12'hFFC, 0);
      chk("slverr", 1'b1, err);
   endtask
   initial
   begin
      cyc(2);
      RST <= 1'b0;
      slow <= 1'b1;
      cyc(2);
      t_sc;
      t_mode;
      t_ext;
      t_e;
      t_p4;
      t_fn;
      t_p9;
      t_mem;
      t_rpin;
      tally_and_finish;
   end
endmodule // pmx_top_tb
